//--- pkg/dxr_map.svh
`ifndef DXR_MAP_SVH
`define DXR_MAP_SVH

// Bus and register widths
`define DXR_DATA_W 16
`define DXR_ADDR_W 16
`define DXR_GREG_W 40
`define DXR_NGREG 8
`define DXR_IDX_W 3

// Field positions inside one general-purpose register
`define DXR_LOW_LSB 0
`define DXR_MID_LSB 16
`define DXR_UPP_LSB 32
`define DXR_UPP_W 8

// Address decode: addr[15:14] region code, peripheral window on addr[15:10]
`define DXR_RAM_REGION 2'h0
`define DXR_ROM_REGION 2'h1
`define DXR_PER_BASE 6'h20

`endif

//--- pkg/dxr_pkg.sv
`include "dxr_map.svh"
`default_nettype none
package dxr_pkg;

  typedef logic [`DXR_DATA_W-1:0] dxr_word_t;
  typedef logic [`DXR_ADDR_W-1:0] dxr_addr_t;
  typedef logic [`DXR_GREG_W-1:0] dxr_greg_t;
  typedef logic [`DXR_IDX_W-1:0] dxr_idx_t;

  // Register part moved by a transfer
  typedef enum logic [2:0] {
    PART_LOW = 3'b000,
    PART_MID = 3'b001,
    PART_UPP = 3'b010,
    PART_UPMID = 3'b011,
    PART_WHOLE = 3'b100
  } dxr_part_t;

  // Decoded target of one access
  typedef enum logic [1:0] {
    TGT_RAM = 2'b00,
    TGT_ROM = 2'b01,
    TGT_PER = 2'b10,
    TGT_EXT = 2'b11
  } dxr_tgt_t;

  // Background transfer sequencer
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b000,
    DMA_READ = 3'b001,
    DMA_LAT1 = 3'b010,
    DMA_LAT2 = 3'b011,
    DMA_WRITE = 3'b100
  } dxr_dma_st_t;

  // Core load/store request on one data path
  typedef struct packed {
    logic valid;
    logic write;
    dxr_addr_t addr;
    dxr_idx_t regIdx;
    dxr_part_t part;
  } dxr_req_t;

  // Strobe group toward one memory or register target
  typedef struct packed {
    logic en;
    logic we;
    dxr_addr_t addr;
    dxr_word_t wdata;
  } dxr_mem_t;

  // Load waiting for its read data
  typedef struct packed {
    logic valid;
    dxr_tgt_t tgt;
    dxr_idx_t regIdx;
    dxr_part_t part;
  } dxr_pend_t;

  // Transfer request between peripheral and memory, direction set by toMem
  typedef struct packed {
    logic valid;
    logic toMem;
    logic ySpace;
    dxr_addr_t memAddr;
    dxr_addr_t perAddr;
  } dxr_dma_req_t;

endpackage
`default_nettype wire

//--- logic/dxr_router.sv
`include "dxr_map.svh"
`default_nettype none

module dxr_router (
  input wire logic mclk,
  input wire logic rst,
  input wire dxr_pkg::dxr_req_t xReq,
  input wire dxr_pkg::dxr_req_t yReq,
  input wire dxr_pkg::dxr_dma_req_t dmaReq,
  input wire dxr_pkg::dxr_word_t xRamRdata,
  input wire dxr_pkg::dxr_word_t yRamRdata,
  input wire dxr_pkg::dxr_word_t xRomRdata,
  input wire dxr_pkg::dxr_word_t yRomRdata,
  input wire dxr_pkg::dxr_word_t perRdata,
  input wire dxr_pkg::dxr_word_t extRdata,
  input wire dxr_pkg::dxr_idx_t regRdIdx,
  output var dxr_pkg::dxr_mem_t xRam,
  output var dxr_pkg::dxr_mem_t yRam,
  output var dxr_pkg::dxr_mem_t xRom,
  output var dxr_pkg::dxr_mem_t yRom,
  output var dxr_pkg::dxr_mem_t per,
  output var dxr_pkg::dxr_mem_t ext,
  output var dxr_pkg::dxr_greg_t regRdData,
  output var logic conflict,
  output var logic dmaBusy,
  output var logic dmaDone
);
  import dxr_pkg::*;

  // Whole state of the router in one register
  typedef struct packed {
    logic [`DXR_NGREG-1:0][`DXR_GREG_W-1:0] regs;
    dxr_mem_t [1:0] ram;
    dxr_mem_t [1:0] rom;
    dxr_mem_t per;
    dxr_mem_t ext;
    dxr_pend_t [1:0] p1;
    dxr_pend_t [1:0] p2;
    dxr_dma_st_t dmaSt;
    dxr_dma_req_t dmaCur;
    dxr_word_t dmaData;
    logic dmaBusy;
    logic dmaDone;
    logic conflict;
    dxr_greg_t regRd;
  } dxr_state_t;

  dxr_state_t s_q;
  dxr_state_t s_d;

  // Path-indexed views: index 0 is X, index 1 is Y
  dxr_req_t req [2];
  dxr_word_t ramRd [2];
  dxr_word_t romRd [2];

  assign req[0] = xReq;
  assign req[1] = yReq;
  assign ramRd[0] = xRamRdata;
  assign ramRd[1] = yRamRdata;
  assign romRd[0] = xRomRdata;
  assign romRd[1] = yRomRdata;

  // Single decode, so a target is never selected twice
  function automatic dxr_tgt_t tgtOf(input dxr_addr_t a);
    dxr_tgt_t t;
    t = TGT_EXT;
    if (a[`DXR_ADDR_W-1 -: 2] == `DXR_RAM_REGION) begin
      t = TGT_RAM;
    end else if (a[`DXR_ADDR_W-1 -: 2] == `DXR_ROM_REGION) begin
      t = TGT_ROM;
    end else if (a[`DXR_ADDR_W-1 -: 6] == `DXR_PER_BASE) begin
      t = TGT_PER;
    end
    return t;
  endfunction

  // Register part placed on the 16-bit bus for a store
  function automatic dxr_word_t partOut(input dxr_greg_t r,
                                        input dxr_part_t p);
    dxr_word_t w;
    w = r[`DXR_MID_LSB +: `DXR_DATA_W];
    case (p)
      PART_LOW: w = r[`DXR_LOW_LSB +: `DXR_DATA_W];
      PART_UPP: w = {{`DXR_UPP_W{r[`DXR_GREG_W-1]}},
                     r[`DXR_UPP_LSB +: `DXR_UPP_W]};
      // Middle half serves the middle, upper-and-middle and whole forms
      PART_MID: w = r[`DXR_MID_LSB +: `DXR_DATA_W];
      PART_UPMID: w = r[`DXR_MID_LSB +: `DXR_DATA_W];
      PART_WHOLE: w = r[`DXR_MID_LSB +: `DXR_DATA_W];
      default: w = r[`DXR_MID_LSB +: `DXR_DATA_W];
    endcase
    return w;
  endfunction

  // Register after a load lands in the selected part
  function automatic dxr_greg_t partIn(input dxr_greg_t r,
                                       input dxr_part_t p,
                                       input dxr_word_t w);
    dxr_greg_t n;
    n = r;
    case (p)
      PART_LOW: n[`DXR_LOW_LSB +: `DXR_DATA_W] = w;
      PART_MID: n[`DXR_MID_LSB +: `DXR_DATA_W] = w;
      PART_UPP: n[`DXR_UPP_LSB +: `DXR_UPP_W] = w[`DXR_UPP_W-1:0];
      PART_UPMID: begin
        n[`DXR_MID_LSB +: `DXR_DATA_W] = w;
        n[`DXR_UPP_LSB +: `DXR_UPP_W] = {`DXR_UPP_W{w[`DXR_DATA_W-1]}};
      end
      PART_WHOLE: begin
        n = {{`DXR_UPP_W{w[`DXR_DATA_W-1]}}, w, `DXR_DATA_W'(0)};
      end
      default: n = r; // Illegal part code leaves the register alone
    endcase
    return n;
  endfunction

  // Strobe group for one issued access
  function automatic dxr_mem_t strobe(input logic we, input dxr_addr_t a,
                                      input dxr_word_t w);
    dxr_mem_t m;
    m.en = 1'b1;
    m.we = we;
    m.addr = a;
    m.wdata = w;
    return m;
  endfunction

  // Next-state logic: core paths first, DMA takes what is left
  always_comb begin
    dxr_tgt_t tgt [2];
    logic go [2];
    logic clash;
    dxr_word_t ld;
    dxr_word_t wd;
    logic sp;
    // Locals start from a defined value on every pass
    tgt[0] = TGT_RAM;
    tgt[1] = TGT_RAM;
    go[0] = 1'b0;
    go[1] = 1'b0;
    clash = 1'b0;
    s_d = s_q;
    s_d.ram = '0;
    s_d.rom = '0;
    s_d.per = '0;
    s_d.ext = '0;
    s_d.dmaDone = 1'b0;
    ld = '0;
    wd = '0;
    sp = s_q.dmaCur.ySpace;
    tgt[0] = tgtOf(req[0].addr);
    tgt[1] = tgtOf(req[1].addr);
    // Shared peripheral window and shared external bus cannot serve both
    // X wins, so a bad program loses Y's word but never mixes two words
    clash = req[0].valid && req[1].valid &&
            ((tgt[0] == TGT_PER && tgt[1] == TGT_PER) ||
             (tgt[0] == TGT_EXT && tgt[1] == TGT_EXT));
    s_d.conflict = clash;
    go[0] = req[0].valid;
    go[1] = req[1].valid && !clash;
    // Issue each path; X and Y RAM/ROM ports never interact
    for (int i = 0; i < 2; i++) begin
      wd = partOut(s_q.regs[req[i].regIdx], req[i].part);
      s_d.p1[i] = '0;
      if (go[i]) begin
        unique case (tgt[i])
          TGT_RAM: s_d.ram[i] = strobe(req[i].write, req[i].addr, wd);
          TGT_ROM: begin
            // Store to ROM is dropped, no strobe at all
            if (!req[i].write) begin
              s_d.rom[i] = strobe(1'b0, req[i].addr, wd);
            end
          end
          // Same port and address whichever path issued it
          TGT_PER: s_d.per = strobe(req[i].write, req[i].addr, wd);
          TGT_EXT: s_d.ext = strobe(req[i].write, req[i].addr, wd);
        endcase
        s_d.p1[i].valid = !req[i].write &&
                          !(tgt[i] == TGT_ROM && req[i].write);
        s_d.p1[i].tgt = tgt[i];
        s_d.p1[i].regIdx = req[i].regIdx;
        s_d.p1[i].part = req[i].part;
      end
    end
    // Load data arrives one cycle after its strobe; Y lands last
    for (int i = 0; i < 2; i++) begin
      if (s_q.p2[i].valid) begin
        unique case (s_q.p2[i].tgt)
          TGT_RAM: ld = ramRd[i];
          TGT_ROM: ld = romRd[i];
          TGT_PER: ld = perRdata;
          TGT_EXT: ld = extRdata;
        endcase
        s_d.regs[s_q.p2[i].regIdx] =
          partIn(s_d.regs[s_q.p2[i].regIdx], s_q.p2[i].part, ld);
      end
    end
    s_d.p2 = s_q.p1;
    // Background transfer uses ports only in cycles the core leaves idle
    // Limitation: a core busy on that port every cycle stalls the move
    unique case (s_q.dmaSt)
      DMA_IDLE: begin
        if (dmaReq.valid) begin
          s_d.dmaCur = dmaReq;
          s_d.dmaSt = DMA_READ;
        end
      end
      DMA_READ: begin
        if (s_q.dmaCur.toMem && !s_d.per.en) begin
          s_d.per = strobe(1'b0, s_q.dmaCur.perAddr, '0);
          s_d.dmaSt = DMA_LAT1;
        end else if (!s_q.dmaCur.toMem && !s_d.ram[sp].en) begin
          s_d.ram[sp] = strobe(1'b0, s_q.dmaCur.memAddr, '0);
          s_d.dmaSt = DMA_LAT1;
        end
      end
      DMA_LAT1: s_d.dmaSt = DMA_LAT2;
      DMA_LAT2: begin
        s_d.dmaData = s_q.dmaCur.toMem ? perRdata : ramRd[sp];
        s_d.dmaSt = DMA_WRITE;
      end
      DMA_WRITE: begin
        if (s_q.dmaCur.toMem && !s_d.ram[sp].en) begin
          s_d.ram[sp] = strobe(1'b1, s_q.dmaCur.memAddr, s_q.dmaData);
          s_d.dmaDone = 1'b1;
          s_d.dmaSt = DMA_IDLE;
        end else if (!s_q.dmaCur.toMem && !s_d.per.en) begin
          s_d.per = strobe(1'b1, s_q.dmaCur.perAddr, s_q.dmaData);
          s_d.dmaDone = 1'b1;
          s_d.dmaSt = DMA_IDLE;
        end
      end
      default: s_d.dmaSt = DMA_IDLE; // Unused codes recover to idle
    endcase
    s_d.dmaBusy = (s_d.dmaSt != DMA_IDLE);
    // Observation port shows the register as it stood at the previous edge, one cycle late
    s_d.regRd = s_q.regs[regRdIdx];
  end

  // State register, cleared by reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs are straight flop copies
  assign xRam = s_q.ram[0];
  assign yRam = s_q.ram[1];
  assign xRom = s_q.rom[0];
  assign yRom = s_q.rom[1];
  assign per = s_q.per;
  assign ext = s_q.ext;
  assign regRdData = s_q.regRd;
  assign conflict = s_q.conflict;
  assign dmaBusy = s_q.dmaBusy;
  assign dmaDone = s_q.dmaDone;

endmodule // dxr_router
`default_nettype wire

//--- test/dxr_router_chk.sv
`include "dxr_map.svh"
`default_nettype none
module dxr_router_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire dxr_pkg::dxr_req_t xReq,
  input wire dxr_pkg::dxr_req_t yReq,
  input wire dxr_pkg::dxr_dma_req_t dmaReq,
  input wire dxr_pkg::dxr_mem_t xRam,
  input wire dxr_pkg::dxr_mem_t yRam,
  input wire dxr_pkg::dxr_mem_t xRom,
  input wire dxr_pkg::dxr_mem_t per,
  input wire dxr_pkg::dxr_mem_t ext,
  input wire logic conflict,
  input wire logic dmaBusy,
  input wire logic dmaDone
);
  timeunit 1ns;
  timeprecision 1ps;
  import dxr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Own decode of the address map, so a slip in the design's shows
  function automatic dxr_tgt_t tgtOf(dxr_req_t r);
    if (r.addr[15:14] == `DXR_RAM_REGION) return TGT_RAM;
    if (r.addr[15:14] == `DXR_ROM_REGION) return TGT_ROM;
    return (r.addr[15:10] == `DXR_PER_BASE) ? TGT_PER : TGT_EXT;
  endfunction
  // Requests that compete for a shared target
  wire logic xPer = xReq.valid && tgtOf(xReq) == TGT_PER;
  wire logic yPer = yReq.valid && tgtOf(yReq) == TGT_PER;
  wire logic xExt = xReq.valid && tgtOf(xReq) == TGT_EXT;
  wire logic yExt = yReq.valid && tgtOf(yReq) == TGT_EXT;
  a_x_ram_strobe: assert property (
    xReq.valid && tgtOf(xReq) == TGT_RAM |=> xRam.en
    && xRam.we == $past(xReq.write) && xRam.addr == $past(xReq.addr))
    else $error("X RAM strobe wrong");
  a_y_ram_strobe: assert property (
    yReq.valid && tgtOf(yReq) == TGT_RAM
    |=> yRam.en && yRam.addr == $past(yReq.addr))
    else $error("Y RAM strobe wrong");
  a_rom_no_store: assert property (
    xReq.valid && xReq.write && tgtOf(xReq) == TGT_ROM |=> !xRom.en)
    else $error("ROM store strobed");
  a_per_clash: assert property (
    xPer && yPer |=> conflict && per.addr == $past(xReq.addr))
    else $error("peripheral clash not flagged");
  a_ext_clash: assert property (
    xExt && yExt |=> conflict && ext.addr == $past(xReq.addr))
    else $error("external clash not flagged");
  a_per_shared: assert property (
    yPer && !xPer |=> per.en && per.addr == $past(yReq.addr))
    else $error("Y peripheral access lost");
  a_dma_take: assert property (
    dmaReq.valid && !dmaBusy |=> (dmaBusy && !dmaDone) ##1 !dmaDone [*3])
    else $error("DMA take wrong");
  a_dma_done_end: assert property (
    dmaDone |-> (!dmaBusy && (xRam.we || yRam.we || per.we)) ##1 !dmaDone)
    else $error("DMA end wrong");
  c_clash: cover property (conflict);
  c_dma: cover property (dmaDone);
  c_dual: cover property (xRam.en && yRam.en);
endmodule // dxr_router_chk

bind dxr_router dxr_router_chk chk (.mclk(mclk), .rst(rst), .xReq(xReq),
  .yReq(yReq), .dmaReq(dmaReq), .xRam(xRam), .yRam(yRam), .xRom(xRom),
  .per(per), .ext(ext), .conflict(conflict), .dmaBusy(dmaBusy),
  .dmaDone(dmaDone));
`default_nettype wire

//--- test/dxr_mem_model.sv
`default_nettype none
module dxr_mem_model #(
  parameter int unsigned TAG = 1
) (
  input wire logic mclk,
  input wire dxr_pkg::dxr_mem_t bus,
  output var dxr_pkg::dxr_word_t rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dxr_pkg::*;
  // Target number picks the content pattern; numbers 3 and 4 are ROMs
  localparam dxr_word_t SALT = {4{4'(TAG)}};
  localparam bit ROM = (TAG == 3) || (TAG == 4);
  dxr_word_t mem [256];
  // Unwritten words hold a pattern of their own address
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {i[7:0], i[7:0]} ^ SALT;
    end
  end
  // Data only in the cycle after the strobe, scrambled otherwise
  always @(posedge mclk) begin
    rdata <= (bus.en && !bus.we) ? mem[bus.addr[7:0]] : ~rdata;
    if (bus.en && bus.we && !ROM) begin
      mem[bus.addr[7:0]] <= bus.wdata;
    end
  end
endmodule // dxr_mem_model
`default_nettype wire

//--- test/dxr_router_bench.sv
`include "dxr_map.svh"
`default_nettype none
module dxr_router_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dxr_pkg::*;
  logic mclk, rst, conflict, dmaBusy, dmaDone;
  dxr_req_t xReq, yReq;
  dxr_dma_req_t dmaReq;
  dxr_idx_t regRdIdx;
  dxr_word_t xRamRd, yRamRd, xRomRd, yRomRd, perRd, extRd;
  dxr_mem_t xRam, yRam, xRom, yRom, per, ext;
  dxr_greg_t regRdData;
  dxr_greg_t regs [8];
  int mismatches, compares;
  logic [31:0] lfsrState;

  dxr_router dut (.mclk(mclk), .rst(rst), .xReq(xReq), .yReq(yReq),
    .dmaReq(dmaReq), .xRamRdata(xRamRd), .yRamRdata(yRamRd),
    .xRomRdata(xRomRd), .yRomRdata(yRomRd), .perRdata(perRd),
    .extRdata(extRd), .regRdIdx(regRdIdx), .xRam(xRam), .yRam(yRam),
    .xRom(xRom), .yRom(yRom), .per(per), .ext(ext), .conflict(conflict),
    .regRdData(regRdData), .dmaBusy(dmaBusy), .dmaDone(dmaDone));
  // Far-side targets, each with its own content pattern
  dxr_mem_model mXRam (.mclk, .bus(xRam), .rdata(xRamRd));
  dxr_mem_model #(.TAG(2)) mYRam (.mclk, .bus(yRam), .rdata(yRamRd));
  dxr_mem_model #(.TAG(3)) mXRom (.mclk, .bus(xRom), .rdata(xRomRd));
  dxr_mem_model #(.TAG(4)) mYRom (.mclk, .bus(yRom), .rdata(yRomRd));
  dxr_mem_model #(.TAG(5)) mPer (.mclk, .bus(per), .rdata(perRd));
  dxr_mem_model #(.TAG(6)) mExt (.mclk, .bus(ext), .rdata(extRd));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic dxr_word_t memWord(dxr_addr_t a, dxr_word_t salt);
    return {a[7:0], a[7:0]} ^ salt;
  endfunction
  function automatic dxr_greg_t loadPart(dxr_greg_t r, dxr_part_t p,
      dxr_word_t w);
    case (p)
      PART_LOW: r[15:0] = w;
      PART_MID: r[31:16] = w;
      PART_UPP: r[39:32] = w[7:0];
      PART_UPMID: r = {{8{w[15]}}, w, r[15:0]};
      default: r = {{8{w[15]}}, w, 16'h0000};
    endcase
    return r;
  endfunction
  function automatic dxr_word_t storePart(dxr_greg_t r, dxr_part_t p);
    if (p == PART_LOW) return r[15:0];
    if (p == PART_UPP) return {{8{r[39]}}, r[39:32]};
    return r[31:16];
  endfunction
  function automatic dxr_req_t mk(logic w, dxr_addr_t a, dxr_idx_t i,
      dxr_part_t p);
    return {1'b1, w, a, i, p};
  endfunction

  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chkVal(string what, logic [39:0] exp, logic [39:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkBus(string what, dxr_mem_t exp, dxr_mem_t got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Requests stand for exactly one taking edge
  task automatic go(dxr_req_t rx, dxr_req_t ry);
    @(posedge mclk);
    xReq <= rx;
    yReq <= ry;
    @(posedge mclk);
    xReq <= '0;
    yReq <= '0;
  endtask
  task automatic side(bit y, dxr_req_t r);
    if (y) go('0, r);
    else go(r, '0);
  endtask
  // Data lands two edges after the take, readback one more
  task automatic load(bit y, dxr_addr_t a, dxr_idx_t i, dxr_part_t p,
      dxr_word_t w);
    side(y, mk(1'b0, a, i, p));
    regRdIdx <= i;
    regs[i] = loadPart(regs[i], p, w);
    repeat (3) @(posedge mclk);
    #1 chkVal("register", regs[i], regRdData);
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (dmaDone !== 1'b1 && n < 40);
    if (dmaDone !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask

  initial begin
    bit y;
    dxr_part_t p;
    dxr_addr_t a, b;
    dxr_idx_t i;
    xReq = '0;
    yReq = '0;
    dmaReq = '0;
    regRdIdx = '0;
    rst = 1'b1;
    mismatches = 0;
    compares = 0;
    lfsrState = 32'hD77F;
    foreach (regs[k]) regs[k] = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chkVal("reset register", '0, regRdData);
    // Every part, both paths: ROM to register, register to RAM and back
    for (int k = 0; k < 10; k++) begin
      y = k[0];
      p = dxr_part_t'(k / 2);
      lfsrState = lfsr(lfsrState);
      a = {2'b01, lfsrState[13:0]};
      b = {2'b00, lfsrState[29:16]};
      i = lfsrState[2:0];
      load(y, a, i, p, memWord(a, y ? 16'h4444 : 16'h3333));
      side(y, mk(1'b1, b, i, p));
      #1 chkBus("RAM store", {2'b11, b, storePart(regs[i], p)},
        y ? yRam : xRam);
      load(y, b, i ^ 3'h1, PART_LOW, storePart(regs[i], p));
      side(y, mk(1'b1, a, i, p));
      #1 chkVal("ROM strobe", '0, y ? yRom.en : xRom.en);
      load(y, a, i, PART_LOW, memWord(a, y ? 16'h4444 : 16'h3333));
    end
    // Both internal RAM paths in the same cycle; loop left a ROM address
    a = a & 16'h3FFF;
    go(mk(1'b1, a, 3'h1, PART_MID), mk(1'b1, b, 3'h2, PART_LOW));
    #1 chkBus("X RAM", {2'b11, a, regs[1][31:16]}, xRam);
    chkBus("Y RAM", {2'b11, b, regs[2][15:0]}, yRam);
    // Clash on peripheral, then external; Y alone afterwards
    for (int k = 0; k < 2; k++) begin
      lfsrState = lfsr(lfsrState);
      a = k ? {2'b11, lfsrState[13:0]} : {`DXR_PER_BASE, lfsrState[9:0]};
      b = k ? {2'b11, lfsrState[29:16]} : {`DXR_PER_BASE, lfsrState[25:16]};
      a = a & 16'hFF7F;
      b = b & 16'hFF7F;
      go(mk(1'b1, a, 3'h3, PART_LOW), mk(1'b1, b, 3'h4, PART_LOW));
      #1 chkBus("shared", {2'b11, a, regs[3][15:0]}, k ? ext : per);
      chkVal("conflict", 40'h1, conflict);
      side(1'b1, mk(1'b1, b, 3'h4, PART_LOW));
      #1 chkBus("Y alone", {2'b11, b, regs[4][15:0]}, k ? ext : per);
      chkVal("no conflict", '0, conflict);
      // X reads back what Y stored at the same shared address
      load(1'b0, b, 3'h5, PART_LOW, regs[4][15:0]);
    end
    // Background moves: peripheral to RAM, then the word back out
    lfsrState = lfsr(lfsrState);
    a = {`DXR_PER_BASE, lfsrState[9:0]} | 16'h0080;
    b = {2'b00, lfsrState[29:16]};
    for (int k = 1; k >= 0; k--) begin
      @(posedge mclk);
      dmaReq <= {1'b1, k[0], 1'b0, b, a};
      @(posedge mclk);
      dmaReq <= '0;
      waitDone();
      chkVal("DMA busy", '0, dmaBusy);
      chkBus("DMA write", {2'b11, k ? b : a, memWord(a, 16'h5555)},
        k ? xRam : per);
    end
    repeat (4) @(posedge mclk);
    complete_run();
  end
endmodule // dxr_router_bench
`default_nettype wire
